// file: bench/test_timer_pair_joint_control.sv
`timescale 1ns/100ps
module test_timer_pair_joint_control;
  import timer_pair_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rdata, err;
  logic wide_toggle, wide_demod, narrow_out_raw, narrow_timeout, carrier_pin;
  logic wide_counter_run, narrow_counter_run, wide_timer_out, narrow_timer_out, v;
  capture_evt_t narrow_capture_evt;
  int fails, n_tests, ncap, nirq;
  logic [31:0] ta[8] = '{'hc, 'h8, 'hc, 'h8, 'hc, 'h0, 'hc, 'h0};
  logic [31:0] td[8] = '{0, 'h80, 'h80, 0, 0, 'h80, 'h40, 0};
  logic [31:0] te[8] = '{0, 2, 2, 2, 0, 1, 1, 1};
  timer_pair_joint_control DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .wide_toggle, .wide_demod, .narrow_out_raw, .narrow_timeout,
    .carrier_pin, .wide_counter_run, .narrow_counter_run, .wide_timer_out, .narrow_timer_out,
    .narrow_capture_evt);
  initial
  begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    if (narrow_capture_evt.capture === 1'b1) ncap++;
    if (narrow_capture_evt.irq === 1'b1) nirq++;
  end
  ////////////////////////////////////////////////////////////////
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (i >= 20)
    begin
      fails++;
      finish_test;
    end
    rdata = prdata;
    err = {31'h0, pslverr};
    psel <= 0;
    penable <= 0;
    @(negedge pclk);
  endtask : apb
  task edges(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      carrier_pin <= ~carrier_pin;
      repeat (10) @(posedge pclk);
    end
    @(negedge pclk);
  endtask : edges
  ////////////////////////////////////////////////////////////////
  initial
  begin
    {presetn, psel, penable, pwrite, wide_toggle, wide_demod} = 0;
    {narrow_out_raw, narrow_timeout, carrier_pin} = 0;
    {paddr, pwdata} = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    apb(0, 'hc, 0);
    check("joint reset", rdata, 32'h07);
    apb(1, 'hc, 'hc0);
    check("joint runs", {30'h0, wide_counter_run, narrow_counter_run}, 3);
    apb(0, 'hc, 0);
    check("joint read", rdata, 32'hc7);
    $display("test joint start done");
    for (int i = 0; i < 8; i++)
    begin
      apb(1, ta[i], td[i]);
      check("run pair", {30'h0, wide_counter_run, narrow_counter_run}, te[i]);
    end
    $display("test mirrored enables done");
    apb(1, 'hc, 'h10);
    v = wide_timer_out;
    repeat (3)
    begin
      @(posedge pclk);
      wide_toggle <= ~wide_toggle;
      repeat (2) @(negedge pclk);
      check("frozen out", {31'h0, wide_timer_out}, {31'h0, v});
    end
    apb(1, 'hc, 0);
    @(posedge pclk);
    wide_toggle <= ~wide_toggle;
    narrow_out_raw <= 1;
    repeat (2) @(negedge pclk);
    check("wide out", {31'h0, wide_timer_out}, {31'h0, wide_toggle});
    check("narrow out", {31'h0, narrow_timer_out}, 1);
    apb(1, 'hc, 'h20);
    @(posedge pclk);
    narrow_out_raw <= 0;
    repeat (2) @(negedge pclk);
    check("synced hold", {31'h0, narrow_timer_out}, 1);
    @(posedge pclk);
    wide_demod <= 1;
    repeat (2) @(negedge pclk);
    check("synced follow", {31'h0, narrow_timer_out}, 0);
    $display("test outputs done");
    apb(1, 'hc, 'h48);
    repeat (2)
    begin
      {ncap, nirq} = 0;
      edges(5);
      check("single captures", ncap, 2);
      check("single irq", nirq, 1);
      apb(0, 'h10, 0);
      check("status done", rdata, 32'h48);
      @(posedge pclk);
      narrow_timeout <= 1;
      @(posedge pclk);
      narrow_timeout <= 0;
    end
    apb(1, 'hc, 'h40);
    {ncap, nirq} = 0;
    edges(3);
    check("normal captures", ncap, 3);
    check("normal irq", nirq, 0);
    apb(0, 'h10, 0);
    check("status normal", rdata, 32'h41);
    $display("test capture done");
    apb(0, 'h14, 0);
    check("unmapped err", err, 1);
    check("unmapped data", rdata, 0);
    $display("test unmapped done");
    finish_test;
  end
endmodule : test_timer_pair_joint_control

// file: bench/timer_pair_joint_control_properties.sv
`timescale 1ns/100ps
module timer_pair_joint_control_properties
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wide_toggle,
  input wire logic wide_demod,
  input wire logic narrow_out_raw,
  input wire logic wide_counter_run,
  input wire logic narrow_counter_run,
  input wire logic wide_timer_out,
  input wire logic narrow_timer_out,
  input wire timer_pair_pkg::capture_evt_t narrow_capture_evt
);
  import timer_pair_pkg::*;
  logic [4:0] joint_ff;
  logic [1:0] own_ff;
  wire wr = psel & penable & pready & pwrite;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      joint_ff <= 5'h00;
      own_ff <= 2'h0;
    end
    else if (wr)
    begin
      if (paddr == 32'hc) joint_ff <= pwdata[7:3];
      if (paddr == 32'h8) own_ff[1] <= pwdata[7];
      if (paddr == 32'h0) own_ff[0] <= pwdata[7];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  chk_joint_start: assert property (
    wr && paddr == 32'hc && pwdata[7:6] == 2'h3 |=> wide_counter_run && narrow_counter_run)
    else $error("joint start missing");
  chk_wide_run: assert property (
    wide_counter_run == (joint_ff[4] | own_ff[1])) else $error("wide run wrong");
  chk_narrow_run: assert property (
    narrow_counter_run == (joint_ff[3] | own_ff[0])) else $error("narrow run wrong");
  chk_freeze_hold: assert property (
    $past(joint_ff[1]) |-> $stable(wide_timer_out)) else $error("frozen output moved");
  chk_out_follow: assert property (
    $past(presetn, 2) && !$past(joint_ff[1]) |-> wide_timer_out == $past(wide_toggle))
    else $error("wide output not following");
  chk_irq_single: assert property (
    narrow_capture_evt.irq |-> narrow_capture_evt.capture && $past(joint_ff[0]))
    else $error("irq outside single capture");
  chk_irq_once: assert property (
    narrow_capture_evt.irq |=> !narrow_capture_evt.irq) else $error("irq too long");
  chk_narrow_plain: assert property (
    $past(presetn, 2) && !$past(joint_ff[2]) |-> narrow_timer_out == $past(narrow_out_raw))
    else $error("narrow output not following");
  chk_sync_hold: assert property (
    $past(presetn, 2) && $past(joint_ff[2]) && $past(wide_demod) == $past(wide_demod, 2)
    |-> $stable(narrow_timer_out)) else $error("synced output moved");
  chk_sync_follow: assert property (
    $past(presetn, 2) && $past(joint_ff[2]) && $past(wide_demod) != $past(wide_demod, 2)
    |-> narrow_timer_out == $past(narrow_out_raw)) else $error("synced output not sampled");
  chk_err_unmapped: assert property (
    psel && !penable && paddr == 32'h14 |=> pready && pslverr) else $error("no error");
  cov_start: cover property (wr && paddr == 32'hc && pwdata[7:6] == 2'h3);
  cov_irq: cover property (narrow_capture_evt.irq);
  cov_freeze: cover property (joint_ff[1] && $changed(wide_toggle));
  cov_sync: cover property (joint_ff[2] && $changed(wide_demod));
endmodule : timer_pair_joint_control_properties
bind timer_pair_joint_control timer_pair_joint_control_properties u_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .wide_toggle, .narrow_out_raw,
  .wide_counter_run, .narrow_counter_run, .wide_timer_out, .narrow_timer_out,
  .wide_demod, .narrow_capture_evt);

// file: core/timer_pair_defines.svh
`ifndef TIMER_PAIR_DEFINES_SVH
`define TIMER_PAIR_DEFINES_SVH

// register indexes, byte address is four times the index
`define NARROW_CTRL_IDX 3'h0
`define WIDE_CTRL_IDX 3'h2
`define JOINT_CTRL_IDX 3'h3
`define PAIR_STATUS_IDX 3'h4

// joint control field positions
`define JOINT_WIDE_RUN_BIT 7
`define JOINT_NARROW_RUN_BIT 6
`define JOINT_SYNC_BIT 5
`define JOINT_FREEZE_BIT 4
`define JOINT_SINGLE_BIT 3

// own enable bit of each timer control register
`define OWN_RUN_BIT 7

// reset and read values
`define JOINT_RESET 5'h00
`define JOINT_RSVD_READ 3'h7

// carrier edges counted before the single capture is armed
`define CAP_ARM_WAITS 2'h2

`endif

// file: core/timer_pair_joint_control.sv
// Operation
// - both enables in one write start together
// - narrow run is joint bit or own bit
// - freeze holds wide output at present level
// - bit three selects single carrier capture
// - arm third, capture fourth fifth, timeout resets
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`include "timer_pair_defines.svh"

module timer_pair_joint_control
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wide_toggle,
  input wire logic wide_demod,
  input wire logic narrow_out_raw,
  input wire logic narrow_timeout,
  input wire logic carrier_pin,
  output logic wide_counter_run,
  output logic narrow_counter_run,
  output logic wide_timer_out,
  output logic narrow_timer_out,
  output timer_pair_pkg::capture_evt_t narrow_capture_evt
);
  import timer_pair_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  joint_ctrl_t joint_ff;
  logic narrow_own_ff;
  logic wide_own_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  cap_state_t cap_ff;
  logic carrier_s1_ff;
  logic carrier_s2_ff;
  logic carrier_s3_ff;
  logic carrier_lvl_ff;
  logic wide_out_ff;
  logic narrow_out_ff;
  logic wide_demod_d_ff;
  logic wide_run_ff;
  logic narrow_run_ff;
  capture_evt_t evt_ff;

  wire [2:0] reg_idx = paddr[4:2];
  wire in_range = (paddr[31:5] == 27'h0) && (paddr[1:0] == 2'h0);
  wire hit_narrow = in_range && (reg_idx == `NARROW_CTRL_IDX);
  wire hit_wide = in_range && (reg_idx == `WIDE_CTRL_IDX);
  wire hit_joint = in_range && (reg_idx == `JOINT_CTRL_IDX);
  wire hit_status = in_range && (reg_idx == `PAIR_STATUS_IDX);
  wire hit_any = hit_narrow || hit_wide || hit_joint || hit_status;
  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable && pready_ff;
  wire wr_en = access_ph && pwrite && hit_any;
  wire nxt_pready = setup_ph;

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  wire [7:0] joint_rd = {joint_ff.wide_run, joint_ff.narrow_run, joint_ff.sync_mode,
                         joint_ff.wide_freeze, joint_ff.single_capture, `JOINT_RSVD_READ};
  wire [7:0] narrow_rd = {narrow_own_ff, 7'h00};
  wire [7:0] wide_rd = {wide_own_ff, 7'h00};
  wire [7:0] status_rd = {wide_run_ff, narrow_run_ff, wide_out_ff, narrow_out_ff,
                          cap_ff};
  wire [7:0] rd_byte = hit_joint ? joint_rd :
                       hit_narrow ? narrow_rd :
                       hit_wide ? wide_rd :
                       hit_status ? status_rd : 8'h00;
  wire [31:0] nxt_prdata = (setup_ph && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
  wire nxt_pslverr = setup_ph && !hit_any;

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  wire wr_joint = wr_en && hit_joint;
  wire wr_narrow = wr_en && hit_narrow;
  wire wr_wide = wr_en && hit_wide;
  wire [7:0] wb = pwdata[7:0];
  joint_ctrl_t nxt_joint;
  assign nxt_joint = wr_joint ? {wb[`JOINT_WIDE_RUN_BIT], wb[`JOINT_NARROW_RUN_BIT],
                                 wb[`JOINT_SYNC_BIT], wb[`JOINT_FREEZE_BIT],
                                 wb[`JOINT_SINGLE_BIT]} : joint_ff;
  wire nxt_narrow_own = wr_narrow ? wb[`OWN_RUN_BIT] : narrow_own_ff;
  wire nxt_wide_own = wr_wide ? wb[`OWN_RUN_BIT] : wide_own_ff;

  // both run flags come from the same edge, so one write starts both
  wire nxt_wide_run = nxt_joint.wide_run || nxt_wide_own;
  wire nxt_narrow_run = nxt_joint.narrow_run || nxt_narrow_own;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      joint_ff <= `JOINT_RESET;
      narrow_own_ff <= 1'b0;
      wide_own_ff <= 1'b0;
      wide_run_ff <= 1'b0;
      narrow_run_ff <= 1'b0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
    else
    begin
      joint_ff <= nxt_joint;
      narrow_own_ff <= nxt_narrow_own;
      wide_own_ff <= nxt_wide_own;
      wide_run_ff <= nxt_wide_run;
      narrow_run_ff <= nxt_narrow_run;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer outputs

  // freeze keeps the last level while the counter keeps toggling
  wire nxt_wide_out = joint_ff.wide_freeze ? wide_out_ff : wide_toggle;
  // in sync mode the narrow output only moves on a wide demod edge
  wire demod_edge = wide_demod ^ wide_demod_d_ff;
  wire nxt_narrow_out = !joint_ff.sync_mode ? narrow_out_raw :
                        demod_edge ? narrow_out_raw : narrow_out_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wide_out_ff <= 1'b0;
      narrow_out_ff <= 1'b0;
      wide_demod_d_ff <= 1'b0;
    end
    else
    begin
      wide_out_ff <= nxt_wide_out;
      narrow_out_ff <= nxt_narrow_out;
      wide_demod_d_ff <= wide_demod;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // carrier pin synchroniser

  wire nxt_carrier_lvl = (carrier_s2_ff == carrier_s3_ff) ? carrier_s3_ff : carrier_lvl_ff;
  wire carrier_edge = (carrier_s2_ff == carrier_s3_ff) && (carrier_s3_ff != carrier_lvl_ff);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      carrier_s1_ff <= 1'b0;
      carrier_s2_ff <= 1'b0;
      carrier_s3_ff <= 1'b0;
      carrier_lvl_ff <= 1'b0;
    end
    else
    begin
      carrier_s1_ff <= carrier_pin;
      carrier_s2_ff <= carrier_s1_ff;
      carrier_s3_ff <= carrier_s2_ff;
      carrier_lvl_ff <= nxt_carrier_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle carrier capture

  logic [1:0] wait_cnt_ff;
  logic [1:0] nxt_wait_cnt;
  cap_state_t nxt_cap;
  capture_evt_t nxt_evt;

  always_comb
  begin
    nxt_cap = cap_ff;
    nxt_wait_cnt = wait_cnt_ff;
    nxt_evt = '0;
    if (!joint_ff.single_capture)
    begin
      nxt_cap = CAP_WAIT;
      nxt_wait_cnt = 2'h0;
      nxt_evt.capture = carrier_edge && narrow_run_ff;
    end
    else if (narrow_timeout)
    begin
      nxt_cap = CAP_WAIT;
      nxt_wait_cnt = 2'h0;
    end
    else if (carrier_edge && narrow_run_ff)
    begin
      case (cap_ff)
        CAP_WAIT:
        begin
          if (wait_cnt_ff == `CAP_ARM_WAITS)
          begin
            nxt_cap = CAP_ARMED;
          end
          else
          begin
            nxt_wait_cnt = wait_cnt_ff + 2'h1;
          end
        end
        CAP_ARMED:
        begin
          nxt_cap = CAP_FIRST;
          nxt_evt.capture = 1'b1;
        end
        CAP_FIRST:
        begin
          nxt_cap = CAP_DONE;
          nxt_evt.capture = 1'b1;
          nxt_evt.irq = 1'b1;
        end
        CAP_DONE:
        begin
          nxt_cap = CAP_DONE;
        end
        default:
        begin
          nxt_cap = CAP_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_ff <= CAP_WAIT;
      wait_cnt_ff <= 2'h0;
      evt_ff <= '0;
    end
    else
    begin
      cap_ff <= nxt_cap;
      wait_cnt_ff <= nxt_wait_cnt;
      evt_ff <= nxt_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign wide_counter_run = wide_run_ff;
  assign narrow_counter_run = narrow_run_ff;
  assign wide_timer_out = wide_out_ff;
  assign narrow_timer_out = narrow_out_ff;
  assign narrow_capture_evt = evt_ff;

endmodule : timer_pair_joint_control

// file: core/timer_pair_pkg.sv
package timer_pair_pkg;

  typedef struct packed {
    logic wide_run;
    logic narrow_run;
    logic sync_mode;
    logic wide_freeze;
    logic single_capture;
  } joint_ctrl_t;

  typedef struct packed {
    logic capture;
    logic irq;
  } capture_evt_t;

  typedef enum logic [3:0] {
    CAP_WAIT  = 4'h1,
    CAP_ARMED = 4'h2,
    CAP_FIRST = 4'h4,
    CAP_DONE  = 4'h8
  } cap_state_t;

endpackage : timer_pair_pkg
